// ### hdl/purs_sequencer.sv
// power-up and reset sequencer with nested reset levels
// Contract
// - supply above power-on threshold starts reference, monitor
// - above brownout level zero: boot continues, start pmu
// - four brownout levels in a two-bit setting
// - startup forces brownout level zero
// - fall below raised level: interrupt, revert to zero
// - five reset levels, each with its own output
// - rtc reset by boot, brownout, power-on only
// - boot policy words only from boot flash region
`timescale 1ns/1ps
module purs_sequencer #(
	parameter int CFG_WORDS_P = purs_pkg::CFG_WORDS
) (
	input wire logic CLOCK_I,
	input wire logic RESET_N_I,
	input wire logic POR_ABOVE_I,
	input wire logic BOR_ABOVE_I,
	input wire logic BOOT_REQ_I,
	input wire logic SYS_REQ_I,
	input wire logic CORE_REQ_I,
	input wire logic LEVEL_WR_I,
	input wire logic [1:0] LEVEL_DATA_I,
	input wire logic CFG_VALID_I,
	input wire logic [31:0] CFG_DATA_I,
	output logic CFG_RD_O,
	output logic [7:0] CFG_ADDR_O,
	output logic [31:0] SWP0_O,
	output logic [31:0] SWP1_O,
	output logic POR_RESET_O,
	output logic BOR_RESET_O,
	output logic BOOT_RESET_O,
	output logic SYS_RESET_O,
	output logic CORE_RESET_O,
	output logic RTC_RESET_O,
	output logic BANDGAP_EN_O,
	output logic BOR_MON_EN_O,
	output logic PMU_EN_O,
	output logic [1:0] BOR_LEVEL_O,
	output logic BOR_IRQ_O,
	output logic BOOT_DONE_O
);
	typedef enum logic [2:0] {
		ST_POR,
		ST_BOR_WAIT,
		ST_CFG_READ,
		ST_RUN
	} purs_state_t;

	typedef struct packed {
		purs_state_t state;
		logic por_s1;
		logic por_s2;
		logic bor_s1;
		logic bor_s2;
		logic [3:0] settle;
		logic [3:0] sys_cnt;
		logic [3:0] core_cnt;
		logic [7:0] idx;
		logic cfg_rd;
		logic [7:0] cfg_addr;
		logic [31:0] swp0;
		logic [31:0] swp1;
		logic por_rst;
		logic bor_rst;
		logic boot_rst;
		logic sys_rst;
		logic core_rst;
		logic rtc_rst;
		logic bandgap_en;
		logic bor_mon_en;
		logic pmu_en;
		logic [1:0] level;
		logic irq;
		logic boot_done;
	} purs_regs_t;

	localparam purs_regs_t RESET_REGS = '{
		state: ST_POR,
		por_s1: 1'b0,
		por_s2: 1'b0,
		bor_s1: 1'b0,
		bor_s2: 1'b0,
		settle: purs_pkg::CNT_ZERO,
		sys_cnt: purs_pkg::CNT_ZERO,
		core_cnt: purs_pkg::CNT_ZERO,
		idx: purs_pkg::IDX_ZERO,
		cfg_rd: 1'b0,
		cfg_addr: purs_pkg::CFG_REGION_BASE,
		swp0: 32'h0,
		swp1: 32'h0,
		por_rst: 1'b1,
		bor_rst: 1'b1,
		boot_rst: 1'b1,
		sys_rst: 1'b1,
		core_rst: 1'b1,
		rtc_rst: 1'b1,
		bandgap_en: 1'b0,
		bor_mon_en: 1'b0,
		pmu_en: 1'b0,
		level: purs_pkg::BOR_LEVEL_ZERO,
		irq: 1'b0,
		boot_done: 1'b0
	};

	function automatic logic [3:0] count_down(input logic [3:0] c);
		count_down = (c == purs_pkg::CNT_ZERO) ? c : c - purs_pkg::CNT_ONE;
	endfunction

	purs_regs_t r;
	purs_regs_t next_r;
	logic drop;
	logic wr_ok;

	// brownout drop seen only once the comparator settled on the level
	assign drop = r.bor_mon_en && !r.bor_s2 && r.settle == purs_pkg::CNT_ZERO;
	assign wr_ok = r.state == ST_RUN && LEVEL_WR_I && !drop;

	always_comb
	begin
		next_r = r;
		next_r.irq = 1'b0;
		next_r.por_s1 = POR_ABOVE_I;
		next_r.por_s2 = r.por_s1;
		next_r.bor_s1 = BOR_ABOVE_I;
		next_r.bor_s2 = r.bor_s1;
		next_r.settle = count_down(r.settle);
		next_r.sys_cnt = count_down(r.sys_cnt);
		next_r.core_cnt = count_down(r.core_cnt);
		next_r.cfg_rd = 1'b0;
		case (r.state)
			ST_POR:
			begin
				next_r.level = purs_pkg::BOR_LEVEL_ZERO;
				if (r.por_s2)
				begin
					next_r.state = ST_BOR_WAIT;
					next_r.bandgap_en = 1'b1;
					next_r.bor_mon_en = 1'b1;
					next_r.settle = purs_pkg::SETTLE_LOAD;
				end
			end
			ST_BOR_WAIT:
			begin
				next_r.level = purs_pkg::BOR_LEVEL_ZERO;
				if (r.bor_s2 && r.settle == purs_pkg::CNT_ZERO)
				begin
					next_r.state = ST_CFG_READ;
					next_r.pmu_en = 1'b1;
					next_r.idx = purs_pkg::IDX_ZERO;
				end
			end
			ST_CFG_READ:
			begin
				next_r.level = purs_pkg::BOR_LEVEL_ZERO;
				next_r.cfg_rd = 1'b1;
				next_r.cfg_addr = purs_pkg::CFG_REGION_BASE + r.idx;
				if (r.cfg_rd && CFG_VALID_I)
				begin
					next_r.cfg_rd = 1'b0;
					if (r.idx == purs_pkg::CFG_IDX_SWP0)
						next_r.swp0 = CFG_DATA_I;
					if (r.idx == purs_pkg::CFG_IDX_SWP1)
						next_r.swp1 = CFG_DATA_I;
					if (r.idx == 8'(CFG_WORDS_P - 1))
					begin
						next_r.state = ST_RUN;
						next_r.boot_done = 1'b1;
					end
					else
						next_r.idx = r.idx + purs_pkg::IDX_ONE;
				end
			end
			ST_RUN:
			begin
				if (BOOT_REQ_I)
				begin
					next_r.state = ST_CFG_READ;
					next_r.boot_done = 1'b0;
					next_r.idx = purs_pkg::IDX_ZERO;
					next_r.level = purs_pkg::BOR_LEVEL_ZERO;
				end
				if (SYS_REQ_I)
					next_r.sys_cnt = purs_pkg::PULSE_LOAD;
				if (CORE_REQ_I)
					next_r.core_cnt = purs_pkg::PULSE_LOAD;
				if (wr_ok && !BOOT_REQ_I)
				begin
					next_r.level = LEVEL_DATA_I;
					next_r.settle = purs_pkg::SETTLE_LOAD;
				end
			end
			default:
				next_r.state = ST_POR;
		endcase
		if (drop && r.state != ST_POR && r.state != ST_BOR_WAIT)
		begin
			if (r.level != purs_pkg::BOR_LEVEL_ZERO)
			begin
				next_r.irq = 1'b1;
				next_r.level = purs_pkg::BOR_LEVEL_ZERO;
				next_r.settle = purs_pkg::SETTLE_LOAD;
			end
			else
			begin
				next_r.state = ST_BOR_WAIT;
				next_r.boot_done = 1'b0;
				next_r.settle = purs_pkg::SETTLE_LOAD;
			end
		end
		if (!r.por_s2)
		begin
			next_r.state = ST_POR;
			next_r.bandgap_en = 1'b0;
			next_r.bor_mon_en = 1'b0;
			next_r.pmu_en = 1'b0;
			next_r.boot_done = 1'b0;
			next_r.level = purs_pkg::BOR_LEVEL_ZERO;
		end
		if (next_r.state != ST_RUN)
			next_r.cfg_rd = next_r.state == ST_CFG_READ && next_r.cfg_rd;
		next_r.por_rst = next_r.state == ST_POR;
		next_r.bor_rst = next_r.por_rst || next_r.state == ST_BOR_WAIT;
		next_r.boot_rst = next_r.bor_rst || next_r.state == ST_CFG_READ;
		next_r.sys_rst = next_r.boot_rst || next_r.sys_cnt != purs_pkg::CNT_ZERO;
		next_r.core_rst = next_r.sys_rst || next_r.core_cnt != purs_pkg::CNT_ZERO;
		next_r.rtc_rst = next_r.boot_rst;
	end

	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			r <= RESET_REGS;
		else
			r <= next_r;
	end

	assign CFG_RD_O = r.cfg_rd;
	assign CFG_ADDR_O = r.cfg_addr;
	assign SWP0_O = r.swp0;
	assign SWP1_O = r.swp1;
	assign POR_RESET_O = r.por_rst;
	assign BOR_RESET_O = r.bor_rst;
	assign BOOT_RESET_O = r.boot_rst;
	assign SYS_RESET_O = r.sys_rst;
	assign CORE_RESET_O = r.core_rst;
	assign RTC_RESET_O = r.rtc_rst;
	assign BANDGAP_EN_O = r.bandgap_en;
	assign BOR_MON_EN_O = r.bor_mon_en;
	assign PMU_EN_O = r.pmu_en;
	assign BOR_LEVEL_O = r.level;
	assign BOR_IRQ_O = r.irq;
	assign BOOT_DONE_O = r.boot_done;

	reset_nest_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		BOR_RESET_O |-> BOOT_RESET_O && SYS_RESET_O && CORE_RESET_O)
		else $error("higher reset without lower levels");
	rtc_keep_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		(SYS_RESET_O && !BOOT_RESET_O) |-> !RTC_RESET_O)
		else $error("rtc reset by system reset");
	por_release_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		(POR_RESET_O && r.por_s2) |=> !POR_RESET_O && BANDGAP_EN_O && BOR_MON_EN_O)
		else $error("power-on release did not start reference");
	pmu_start_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		$fell(BOR_RESET_O) |-> PMU_EN_O && BOOT_RESET_O)
		else $error("pmu not started on brownout release");
	start_level_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		BOOT_RESET_O |-> BOR_LEVEL_O == purs_pkg::BOR_LEVEL_ZERO)
		else $error("level not zero during startup");
	drop_irq_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		BOR_IRQ_O |-> BOR_LEVEL_O == purs_pkg::BOR_LEVEL_ZERO
			&& $past(BOR_LEVEL_O) != purs_pkg::BOR_LEVEL_ZERO)
		else $error("interrupt without level revert");
	level_write_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		(wr_ok && !BOOT_REQ_I && r.por_s2) |=> BOR_LEVEL_O == $past(LEVEL_DATA_I))
		else $error("level write not applied");
	cfg_region_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		CFG_RD_O |-> CFG_ADDR_O >= purs_pkg::CFG_REGION_BASE
			&& CFG_ADDR_O < purs_pkg::CFG_REGION_BASE + 8'(CFG_WORDS_P))
		else $error("policy read outside boot region");
	por_loss_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		$fell(r.por_s2) |=> POR_RESET_O && !PMU_EN_O)
		else $error("power-on loss not held in reset");
endmodule

// ### shared/purs_pkg.sv
// constants for the power-up and reset sequencer
package purs_pkg;
	localparam int LEVEL_W = 2;
	localparam logic [1:0] BOR_LEVEL_ZERO = 2'h0;
	localparam int SYNC_STAGES = 2;
	localparam int CFG_ADDR_W = 8;
	localparam logic [7:0] CFG_REGION_BASE = 8'h40;
	localparam int CFG_WORDS = 2;
	localparam logic [7:0] CFG_IDX_SWP0 = 8'h00;
	localparam logic [7:0] CFG_IDX_SWP1 = 8'h01;
	localparam int CLOCK_MHZ = 50;
	localparam int SETTLE_NS = 100;
	localparam int SETTLE_CYCLES = (SETTLE_NS * CLOCK_MHZ + 999) / 1000;
	localparam int RST_PULSE_NS = 200;
	localparam int RST_PULSE_CYCLES = (RST_PULSE_NS * CLOCK_MHZ + 999) / 1000;
	localparam int CNT_W = 4;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [3:0] SETTLE_LOAD = 4'(SETTLE_CYCLES);
	localparam logic [3:0] PULSE_LOAD = 4'(RST_PULSE_CYCLES);
	localparam logic [7:0] IDX_ZERO = 8'h00;
	localparam logic [7:0] IDX_ONE = 8'h01;
	localparam logic [7:0] IDX_LAST = 8'(CFG_WORDS - 1);
endpackage

// ### verification/purs_partner.sv
// partner model: supply threshold detectors and boot config flash
`timescale 1ns/1ps
module purs_partner (
	input wire logic clk_i,
	input wire logic [3:0] supply_i,
	input wire logic [1:0] level_i,
	input wire logic slow_i,
	input wire logic rd_i,
	input wire logic [7:0] addr_i,
	output logic por_above_o,
	output logic bor_above_o,
	output logic valid_o,
	output logic [31:0] data_o
);
	logic gap = 1'b0;
	// brownout comparator follows the selected brownout level; power-on threshold is fixed
	assign por_above_o = supply_i > 4'h1;
	assign bor_above_o = supply_i > 4'h3 + {2'h0, level_i};
	initial valid_o = 1'b0;
	initial data_o = 32'h0;
	always @(negedge clk_i)
	begin
		gap <= rd_i && !gap;
		valid_o <= rd_i && !valid_o && (!slow_i || gap);
		// data toggles unless a read is pending while valid_o is low
		// slow mode marks its words so a fresh reread shows up
		data_o <= (rd_i && !valid_o) ? {slow_i ? 24'h3c3c3c : 24'h5a5a5a, addr_i} : ~data_o;
	end
endmodule

// ### verification/test_power_up_reset_sequencer.sv
// self-checking bench for the power-up and reset sequencer
`timescale 1ns/1ps
module test_power_up_reset_sequencer;
	logic clk = 1'b0, rst_n = 1'b0, boot_req = 1'b0, sys_req = 1'b0, core_req = 1'b0;
	logic lvl_wr = 1'b0, slow = 1'b0, cfg_rd, cfg_valid, por_rst, bor_rst, boot_rst;
	logic sys_rst, core_rst, rtc_rst, bg_en, mon_en, pmu_en, irq, boot_done, por_ab, bor_ab;
	logic [1:0] lvl_data = 2'h0, level;
	logic [3:0] supply = 4'h0;
	logic [7:0] cfg_addr;
	logic [31:0] cfg_data, swp0, swp1;
	int miscompares = 0, check_count = 0, cycles = 0;
	wire [5:0] rsts = {por_rst, bor_rst, boot_rst, sys_rst, core_rst, rtc_rst};
	wire [2:0] ens = {bg_en, mon_en, pmu_en};
	wire [31:0] exp0 = {24'h5a5a5a, purs_pkg::CFG_REGION_BASE + purs_pkg::CFG_IDX_SWP0};
	wire [31:0] exp1 = {24'h5a5a5a, purs_pkg::CFG_REGION_BASE + purs_pkg::CFG_IDX_SWP1};
	purs_sequencer i_dut (.CLOCK_I(clk), .RESET_N_I(rst_n), .POR_ABOVE_I(por_ab),
		.BOR_ABOVE_I(bor_ab), .BOOT_REQ_I(boot_req), .SYS_REQ_I(sys_req),
		.CORE_REQ_I(core_req), .LEVEL_WR_I(lvl_wr), .LEVEL_DATA_I(lvl_data),
		.CFG_VALID_I(cfg_valid), .CFG_DATA_I(cfg_data), .CFG_RD_O(cfg_rd),
		.CFG_ADDR_O(cfg_addr), .SWP0_O(swp0), .SWP1_O(swp1), .POR_RESET_O(por_rst),
		.BOR_RESET_O(bor_rst), .BOOT_RESET_O(boot_rst), .SYS_RESET_O(sys_rst),
		.CORE_RESET_O(core_rst), .RTC_RESET_O(rtc_rst), .BANDGAP_EN_O(bg_en),
		.BOR_MON_EN_O(mon_en), .PMU_EN_O(pmu_en), .BOR_LEVEL_O(level),
		.BOR_IRQ_O(irq), .BOOT_DONE_O(boot_done));
	purs_partner i_partner (.clk_i(clk), .supply_i(supply), .level_i(level), .slow_i(slow),
		.rd_i(cfg_rd), .addr_i(cfg_addr), .por_above_o(por_ab), .bor_above_o(bor_ab),
		.valid_o(cfg_valid), .data_o(cfg_data));
	initial
	begin
		forever #10 clk = ~clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic wait_boot;
		while (boot_done !== 1'b1)
			@(negedge clk);
	endtask
	task automatic write_level(input logic [1:0] v);
		lvl_data = v;
		lvl_wr = 1'b1;
		@(negedge clk);
		lvl_wr = 1'b0;
		@(negedge clk);
	endtask
	task automatic t_power_up;
		check(rsts, 32'h3f);
		check(ens, 32'h0);
		supply = 4'h2;
		while (por_rst !== 1'b0)
			@(negedge clk);
		check(ens, 32'h6);
		check(rsts, 32'h1f);
		write_level(2'h3);
		check(level, 32'h0);
		supply = 4'h9;
		wait_boot();
		check(ens, 32'h7);
		check(rsts, 32'h0);
		check(swp0, exp0);
		check(swp1, exp1);
		check(level, 32'h0);
	endtask
	task automatic t_levels;
		for (int v = 0; v < 4; v++)
		begin
			write_level(2'(v));
			check(level, 32'(v));
		end
		supply = 4'h5;
		while (irq !== 1'b1)
			@(negedge clk);
		check(level, 32'h0);
		check(rsts, 32'h0);
		@(negedge clk);
		check(irq, 32'h0);
		supply = 4'h3;
		while (bor_rst !== 1'b1)
			@(negedge clk);
		check(rsts, 32'h1f);
		supply = 4'h9;
		wait_boot();
	endtask
	task automatic t_pulses;
		int n;
		for (int k = 0; k < 2; k++)
		begin
			sys_req = (k == 0);
			core_req = (k == 1);
			@(negedge clk);
			sys_req = 1'b0;
			core_req = 1'b0;
			check(rsts, k == 0 ? 32'h06 : 32'h02);
			n = 0;
			while (core_rst === 1'b1 && n < 40)
			begin
				n++;
				@(negedge clk);
			end
			check(32'(n), 32'(purs_pkg::RST_PULSE_CYCLES));
		end
	endtask
	task automatic t_boot_req;
		write_level(2'h2);
		check(level, 32'h2);
		slow = 1'b1;
		boot_req = 1'b1;
		@(negedge clk);
		boot_req = 1'b0;
		check(rsts, 32'h0f);
		check(level, 32'h0);
		wait_boot();
		check(swp0, {24'h3c3c3c, purs_pkg::CFG_REGION_BASE + purs_pkg::CFG_IDX_SWP0});
		check(swp1, {24'h3c3c3c, purs_pkg::CFG_REGION_BASE + purs_pkg::CFG_IDX_SWP1});
		slow = 1'b0;
	endtask
	task automatic t_power_down;
		supply = 4'h0;
		while (por_rst !== 1'b1)
			@(negedge clk);
		check(rsts, 32'h3f);
		check(ens, 32'h0);
		supply = 4'h9;
		wait_boot();
		rst_n = 1'b0;
		#1 check(rsts, 32'h3f);
		@(negedge clk);
		rst_n = 1'b1;
		wait_boot();
		check(rsts, 32'h0);
		check(swp0, exp0);
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			print_verdict();
		end
	end
	initial
	begin
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		t_power_up();
		t_levels();
		t_pulses();
		t_boot_req();
		t_power_down();
		print_verdict();
	end
endmodule
